// *** verilog/sdmc_pkg.sv ***
// Constants, command codes and types for the module command timing block.
package sdmc_pkg;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int DQ_W = 64;
	localparam int BYTES = 8;
	localparam int BANK_W = 2;
	localparam int BANKS = 4;
	localparam int ADDR_W = 12;
	localparam int COL_W = 8;
	localparam int A10_POS = 10;
	localparam int CNT_W = 12;
	localparam int INIT_W = 16;
	localparam int T_INIT_US = 200;
	localparam int T_RAS_MIN_NS = 60;
	localparam int T_RAS_MAX_NS = 110000;
	localparam int T_RP_NS = 30;
	localparam int T_RCD_NS = 30;
	localparam int T_RRD_NS = 20;
	localparam int T_RSC_NS = 20;
	localparam int INIT_CYC = (T_INIT_US * 1000000 + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS;
	localparam logic [CNT_W-1:0] RAS_MIN_CYC = CNT_W'((T_RAS_MIN_NS * 1000 +
		CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] RAS_MAX_CYC = CNT_W'(T_RAS_MAX_NS * 1000 /
		CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS * 1000 +
		CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((T_RCD_NS * 1000 +
		CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] RRD_CYC = 4'((T_RRD_NS * 1000 + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS);
	localparam logic [3:0] RSC_CYC = 4'((T_RSC_NS * 1000 + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS);
	localparam logic [3:0] INIT_REFRESH_NUM = 4'h8;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam int MR_CL_LSB = 4;
	localparam int MR_BL_LSB = 0;
	localparam logic [2:0] MR_CL_THREE = 3'h3;
	localparam logic RST_CL3 = 1'h1;
	localparam logic [2:0] RST_BL_CODE = 3'h3;
	typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sdmc_burst_t;
endpackage

// *** verilog/sdmc_bank_timer.sv ***
// Per-bank row timer that flags activate, access and precharge spacing faults.
`timescale 1ns/10ps
module sdmc_bank_timer (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic act_i,
	input wire logic pre_i,
	input wire logic rw_i,
	output logic err_o
);
	import sdmc_pkg::*;
	logic open_q, open_d;
	logic [CNT_W-1:0] act_cnt_q, act_cnt_d;
	logic [CNT_W-1:0] pre_cnt_q, pre_cnt_d;
	logic err_q, err_d;

	always_comb begin
		open_d = open_q;
		act_cnt_d = (&act_cnt_q) ? act_cnt_q : act_cnt_q + CNT_W'(1);
		pre_cnt_d = (&pre_cnt_q) ? pre_cnt_q : pre_cnt_q + CNT_W'(1);
		err_d = 1'b0;
		if (act_i) begin
			err_d = open_q || (pre_cnt_q < RP_CYC);
			open_d = 1'b1;
			act_cnt_d = CNT_W'(1);
		end else if (pre_i) begin
			err_d = open_q && (act_cnt_q < RAS_MIN_CYC);
			open_d = 1'b0;
			pre_cnt_d = CNT_W'(1);
		end else if (rw_i) begin
			err_d = !open_q || (act_cnt_q < RCD_CYC);
		end else if (open_q && act_cnt_q == RAS_MAX_CYC) begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			open_q <= 1'b0;
			act_cnt_q <= '1;
			pre_cnt_q <= '1;
			err_q <= 1'b0;
		end else begin
			open_q <= open_d;
			act_cnt_q <= act_cnt_d;
			pre_cnt_q <= pre_cnt_d;
			err_q <= err_d;
		end
	end

	assign err_o = err_q;
endmodule // sdmc_bank_timer

// *** verilog/sdmc_device.sv ***
// Module-side command decoder, read/write burst latency and timing checker.
//
// Overview of operation
// - Cycle latencies are fixed counts, independent of clock period.
// - Clock enable low makes the device ignore the clock one cycle later.
// - Byte mask during read floats that byte two cycles later.
// - Byte mask during write blocks input data in the same cycle.
// - Precharge in a read burst floats outputs after read latency cycles.
// - Burst stop in a read floats outputs after read latency cycles.
// - Reads or writes may follow each other every cycle.
// - Reads or writes to different banks may be one cycle apart.
`timescale 1ns/10ps
module sdmc_device #(
	parameter int INIT_CYC_P = sdmc_pkg::INIT_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [sdmc_pkg::BANK_W-1:0] bank_i,
	input wire logic [sdmc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sdmc_pkg::BYTES-1:0] dqm_i,
	input wire logic [sdmc_pkg::DQ_W-1:0] dq_i,
	output logic [sdmc_pkg::DQ_W-1:0] dq_o,
	output logic [sdmc_pkg::BYTES-1:0] dq_oe_o,
	output logic arr_rd_o,
	output logic [sdmc_pkg::BYTES-1:0] arr_wr_o,
	output logic [sdmc_pkg::BANK_W-1:0] arr_bank_o,
	output logic [sdmc_pkg::COL_W-1:0] arr_col_o,
	output logic [sdmc_pkg::DQ_W-1:0] arr_wdata_o,
	input wire logic [sdmc_pkg::DQ_W-1:0] arr_rdata_i,
	output logic timing_err_o,
	output logic init_done_o
);
	import sdmc_pkg::*;
	logic [3:0] cmd;
	logic is_act, is_rd, is_wr, is_pre, is_bst, is_mrs, is_ref, is_idle;
	logic term_pre, term_bst;
	logic rbeat, wbeat;
	logic [3:0] burst_len;
	logic en_q, en_d;
	logic cl3_q, cl3_d;
	logic [2:0] bl_q, bl_d;
	sdmc_burst_t burst_q, burst_d;
	logic [3:0] left_q, left_d;
	logic [COL_W-1:0] col_q, col_d;
	logic [BANK_W-1:0] bank_q, bank_d;
	logic [1:0] rpipe_q, rpipe_d;
	logic [BYTES-1:0] mpipe_q, mpipe_d;
	logic [BYTES-1:0] oe_q, oe_d;
	logic [DQ_W-1:0] dq_q, dq_d;
	logic [DQ_W-1:0] hold_q, hold_d;
	logic rd_q, rd_d;
	logic [BYTES-1:0] wr_q, wr_d;
	logic [DQ_W-1:0] wdata_q, wdata_d;

	assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
	assign is_act = en_q && cmd == CMD_ACT;
	assign is_rd = en_q && cmd == CMD_RD;
	assign is_wr = en_q && cmd == CMD_WR;
	assign is_pre = en_q && cmd == CMD_PRE;
	assign is_bst = en_q && cmd == CMD_BST;
	assign is_mrs = en_q && cmd == CMD_MRS;
	assign is_ref = en_q && cmd == CMD_REF;
	assign is_idle = cs_n_i || cmd == CMD_NOP;
	assign term_pre = is_pre && (addr_i[A10_POS] || bank_i == bank_q) &&
		burst_q != BURST_IDLE;
	assign term_bst = is_bst && burst_q != BURST_IDLE;
	assign burst_len = 4'h1 << bl_q[1:0];

	always_comb begin
		en_d = cke_i;
		cl3_d = cl3_q;
		bl_d = bl_q;
		burst_d = burst_q;
		left_d = left_q;
		col_d = col_q;
		bank_d = bank_q;
		rpipe_d = rpipe_q;
		mpipe_d = mpipe_q;
		oe_d = oe_q;
		dq_d = dq_q;
		hold_d = hold_q;
		rd_d = 1'b0;
		wr_d = '0;
		wdata_d = wdata_q;
		rbeat = 1'b0;
		wbeat = 1'b0;
		if (en_q) begin
			if (is_rd || is_wr) begin
				burst_d = (burst_len == 4'h1) ? BURST_IDLE :
					(is_rd ? BURST_READ : BURST_WRITE);
				bank_d = bank_i;
				col_d = addr_i[COL_W-1:0];
				left_d = burst_len - 4'h1;
				rbeat = is_rd;
				wbeat = is_wr;
			end else if (term_pre || term_bst) begin
				burst_d = BURST_IDLE;
			end else if (burst_q != BURST_IDLE) begin
				col_d = col_q + COL_W'(1);
				left_d = left_q - 4'h1;
				if (left_q == 4'h1) begin
					burst_d = BURST_IDLE;
				end
				rbeat = burst_q == BURST_READ;
				wbeat = burst_q == BURST_WRITE;
			end
			if (is_mrs) begin
				cl3_d = addr_i[MR_CL_LSB+:3] == MR_CL_THREE;
				bl_d = addr_i[MR_BL_LSB+:3];
			end
			rpipe_d = {rpipe_q[0], rbeat};
			mpipe_d = dqm_i;
			oe_d = {BYTES{cl3_q ? rpipe_q[1] : rpipe_q[0]}} & ~mpipe_q;
			hold_d = arr_rdata_i;
			dq_d = cl3_q ? hold_q : arr_rdata_i;
			rd_d = rbeat;
			wr_d = {BYTES{wbeat}} & ~dqm_i;
			wdata_d = dq_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			en_q <= 1'b0;
			cl3_q <= RST_CL3;
			bl_q <= RST_BL_CODE;
			burst_q <= BURST_IDLE;
			left_q <= '0;
			col_q <= '0;
			bank_q <= '0;
			rpipe_q <= '0;
			mpipe_q <= '0;
			oe_q <= '0;
			dq_q <= '0;
			hold_q <= '0;
			rd_q <= 1'b0;
			wr_q <= '0;
			wdata_q <= '0;
		end else begin
			en_q <= en_d;
			cl3_q <= cl3_d;
			bl_q <= bl_d;
			burst_q <= burst_d;
			left_q <= left_d;
			col_q <= col_d;
			bank_q <= bank_d;
			rpipe_q <= rpipe_d;
			mpipe_q <= mpipe_d;
			oe_q <= oe_d;
			dq_q <= dq_d;
			hold_q <= hold_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			wdata_q <= wdata_d;
		end
	end

	assign dq_o = dq_q;
	assign dq_oe_o = oe_q;
	assign arr_rd_o = rd_q;
	assign arr_wr_o = wr_q;
	assign arr_bank_o = bank_q;
	assign arr_col_o = col_q;
	assign arr_wdata_o = wdata_q;

	// Checker of the controller's spacing; counters run on real time.
	logic [BANKS-1:0] bank_err;
	logic [3:0] rrd_q, rrd_d;
	logic [3:0] rsc_q, rsc_d;
	logic [INIT_W-1:0] init_cnt_q, init_cnt_d;
	logic [3:0] ref_cnt_q, ref_cnt_d;
	logic init_done_q, init_done_d;
	logic err_q, err_d;
	logic pause_done;

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		sdmc_bank_timer u_timer (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.act_i(is_act && bank_i == BANK_W'(b)),
			.pre_i(is_pre && (addr_i[A10_POS] || bank_i == BANK_W'(b))),
			.rw_i((is_rd || is_wr) && bank_i == BANK_W'(b)),
			.err_o(bank_err[b])
		);
	end

	assign pause_done = init_cnt_q >= INIT_W'(INIT_CYC_P);

	always_comb begin
		rrd_d = (&rrd_q) ? rrd_q : rrd_q + 4'h1;
		rsc_d = (&rsc_q) ? rsc_q : rsc_q + 4'h1;
		init_cnt_d = pause_done ? init_cnt_q : init_cnt_q + INIT_W'(1);
		ref_cnt_d = ref_cnt_q;
		init_done_d = init_done_q;
		err_d = err_q || (|bank_err);
		if (is_act) begin
			rrd_d = 4'h1;
			err_d = err_d || rrd_q < RRD_CYC;
		end
		if (is_mrs) begin
			rsc_d = 4'h1;
		end
		if (en_q && !is_idle) begin
			err_d = err_d || rsc_q < RSC_CYC;
		end
		if (!init_done_q) begin
			if (en_q && !is_idle && !pause_done) begin
				err_d = 1'b1;
			end
			if (is_act || is_rd || is_wr) begin
				err_d = 1'b1;
			end
			if (is_ref && pause_done) begin
				ref_cnt_d = ref_cnt_q + 4'h1;
			end
			init_done_d = ref_cnt_q >= INIT_REFRESH_NUM;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rrd_q <= '1;
			rsc_q <= '1;
			init_cnt_q <= '0;
			ref_cnt_q <= '0;
			init_done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			rrd_q <= rrd_d;
			rsc_q <= rsc_d;
			init_cnt_q <= init_cnt_d;
			ref_cnt_q <= ref_cnt_d;
			init_done_q <= init_done_d;
			err_q <= err_d;
		end
	end

	assign timing_err_o = err_q;
	assign init_done_o = init_done_q;

	a_dqm_float: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(en_q && dqm_i[0]) ##1 en_q |=> !dq_oe_o[0])
		else $error("masked read byte still driven after two cycles");
	a_write_mask: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		wbeat |=> arr_wr_o == ~$past(dqm_i) && arr_wdata_o == $past(dq_i))
		else $error("write mask or data not applied in its own cycle");
	a_cke_freeze: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!cke_i |=> ##1 ($stable(col_q) && $stable(left_q) && !arr_rd_o))
		else $error("state moved while the clock was disabled");
	a_pre_float: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(term_pre && cl3_q) ##1 en_q [*2] |=> dq_oe_o == '0)
		else $error("outputs still driven three cycles after precharge");
	a_bst_float: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(term_bst && !cl3_q) ##1 en_q |=> dq_oe_o == '0)
		else $error("outputs still driven two cycles after burst stop");
	a_latency_three: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(is_rd && cl3_q && dqm_i == '0) ##1 (en_q && dqm_i == '0) ##1 en_q
		|=> &dq_oe_o)
		else $error("read data not driven at latency three");
	a_latency_two: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(is_rd && !cl3_q && dqm_i == '0) ##1 en_q |=> &dq_oe_o)
		else $error("read data not driven at latency two");
	a_back_to_back: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		is_rd ##1 is_rd |=> arr_rd_o && arr_col_o == $past(addr_i[COL_W-1:0]))
		else $error("back to back read not accepted");
	a_bank_switch: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(is_rd || is_wr) ##1 ((is_rd || is_wr) && bank_i != $past(bank_i))
		|=> arr_bank_o == $past(bank_i))
		else $error("access to another bank one cycle later not accepted");

	c_read_burst: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		is_rd ##1 rd_q ##1 rd_q);
	c_write_masked: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		wbeat && dqm_i != '0);
	c_init_done: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(init_done_q));
	c_pre_cut: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		term_pre);
endmodule // sdmc_device

// *** tb/sdmc_ctrl_model.sv ***
// Controller model that drives the command, mask and write data pins.
`timescale 1ns/10ps
module sdmc_ctrl_model (
	input wire logic clk_i,
	output logic cke_o,
	output logic [3:0] cmd_o,
	output logic [sdmc_pkg::BANK_W-1:0] bank_o,
	output logic [sdmc_pkg::ADDR_W-1:0] addr_o,
	output logic [sdmc_pkg::BYTES-1:0] dqm_o,
	output logic [sdmc_pkg::DQ_W-1:0] dq_o
);
	import sdmc_pkg::*;
	// Row cycle spacing in whole clocks, rounded up from the base time.
	localparam int RC_CYC = (90000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	initial begin
		cke_o = 1'b1;
		cmd_o = CMD_NOP;
		bank_o = '0;
		addr_o = '0;
		dqm_o = '0;
		dq_o = 64'ha5a5_5a5a_a5a5_5a5a;
	end

	// Drives one command just after an edge and holds it to the next edge.
	task automatic issue(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [7:0] m, input logic [63:0] d);
		cmd_o = c;
		bank_o = b;
		addr_o = a;
		dqm_o = m;
		dq_o = d;
		@(posedge clk_i);
		#1;
	endtask

	// No-operation for n edges; released lines show inverted values.
	task automatic idle(input int n);
		cmd_o = CMD_NOP;
		bank_o = ~bank_o;
		addr_o = ~addr_o;
		dq_o = ~dq_o;
		repeat (n) begin
			@(posedge clk_i);
			#1;
		end
	endtask

	task automatic gate(input logic v);
		cke_o = v;
	endtask

	// Power-up pause of deselects (chip select high), then eight refreshes.
	task automatic init(input int pause);
		cmd_o = 4'hf;
		repeat (pause) begin
			@(posedge clk_i);
			#1;
		end
		repeat (8) begin
			issue(CMD_REF, 2'h0, 12'h000, 8'h00, dq_o);
			idle(RC_CYC);
		end
	endtask
endmodule // sdmc_ctrl_model

// *** tb/sdmc_device_tb.sv ***
// Self-checking bench for the module command timing block.
`timescale 1ns/10ps
module sdmc_device_tb;
	import sdmc_pkg::*;
	localparam int INIT_P = 20;
	logic clk;
	logic rst;
	logic cke;
	logic [3:0] cmd;
	logic [BANK_W-1:0] bank;
	logic [BANK_W-1:0] arr_bank;
	logic [ADDR_W-1:0] addr;
	logic [BYTES-1:0] dqm;
	logic [BYTES-1:0] dq_oe;
	logic [BYTES-1:0] arr_wr;
	logic [DQ_W-1:0] wdq;
	logic [DQ_W-1:0] rdq;
	logic [DQ_W-1:0] arr_wdata;
	logic [DQ_W-1:0] arr_rdata;
	logic [COL_W-1:0] arr_col;
	logic arr_rd;
	logic err;
	logic done;
	int n_mismatch = 0;
	int num_checks = 0;

	function automatic logic [63:0] rd_pat(input logic [1:0] b,
		input logic [7:0] c);
		return {8{6'h15, b}} ^ {8{c}};
	endfunction

	function automatic logic [63:0] ex(input logic [7:0] m);
		logic [63:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i*8 +: 8] = {8{m[i]}};
		end
		return r;
	endfunction

	assign arr_rdata = rd_pat(arr_bank, arr_col);

	sdmc_ctrl_model ctl (.clk_i(clk), .cke_o(cke), .cmd_o(cmd), .bank_o(bank),
		.addr_o(addr), .dqm_o(dqm), .dq_o(wdq));

	sdmc_device #(.INIT_CYC_P(INIT_P)) dut_u (.clk_i(clk), .sys_rst_i(rst),
		.cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
		.we_n_i(cmd[0]), .bank_i(bank), .addr_i(addr), .dqm_i(dqm),
		.dq_i(wdq), .dq_o(rdq), .dq_oe_o(dq_oe), .arr_rd_o(arr_rd),
		.arr_wr_o(arr_wr), .arr_bank_o(arr_bank), .arr_col_o(arr_col),
		.arr_wdata_o(arr_wdata), .arr_rdata_i(arr_rdata),
		.timing_err_o(err), .init_done_o(done));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic t_write();
		ctl.issue(CMD_MRS, 2'h0, 12'h020, 8'h00, 64'h0);
		ctl.idle(1);
		ctl.issue(CMD_ACT, 2'h0, 12'h011, 8'h00, 64'h0);
		ctl.idle(1);
		ctl.issue(CMD_ACT, 2'h1, 12'h022, 8'h00, 64'h0);
		ctl.idle(1);
		ctl.issue(CMD_WR, 2'h0, 12'h005, 8'h0f, 64'h0123_4567_89ab_cdef);
		chk(arr_wr, 8'hf0);
		chk(arr_wdata, 64'h0123_4567_89ab_cdef);
		chk(arr_col, 8'h05);
		ctl.idle(2);
	endtask

	task automatic t_read_mask();
		ctl.issue(CMD_RD, 2'h0, 12'h007, 8'hc3, 64'h0);
		chk(arr_rd, 1'b1);
		chk(arr_col, 8'h07);
		ctl.idle(1);
		chk(dq_oe, 8'h3c);
		chk(rdq & ex(8'h3c), rd_pat(2'h0, 8'h07) & ex(8'h3c));
		ctl.idle(2);
	endtask

	task automatic t_back_to_back();
		ctl.issue(CMD_RD, 2'h0, 12'h001, 8'h00, 64'h0);
		chk(arr_bank, 2'h0);
		ctl.issue(CMD_RD, 2'h1, 12'h002, 8'h00, 64'h0);
		chk(arr_bank, 2'h1);
		chk(rdq, rd_pat(2'h0, 8'h01));
		ctl.idle(1);
		chk(rdq, rd_pat(2'h1, 8'h02));
		ctl.idle(2);
	endtask

	task automatic t_clock_gate();
		ctl.gate(1'b0);
		ctl.issue(CMD_RD, 2'h0, 12'h003, 8'h00, 64'h0);
		chk(arr_col, 8'h03);
		ctl.issue(CMD_RD, 2'h0, 12'h009, 8'h00, 64'h0);
		chk(arr_col, 8'h03);
		ctl.gate(1'b1);
		ctl.idle(4);
	endtask

	task automatic t_stop();
		ctl.issue(CMD_MRS, 2'h0, 12'h033, 8'h00, 64'h0);
		ctl.idle(1);
		for (int k = 0; k < 2; k++) begin
			ctl.issue(CMD_RD, 2'h0, 12'h010, 8'h00, 64'h0);
			ctl.idle(2);
			ctl.issue(k == 0 ? CMD_BST : CMD_PRE, 2'h0, 12'h000, 8'h00,
				64'h0);
			ctl.idle(1);
			chk(|dq_oe, 1'b1);
			ctl.idle(1);
			chk(dq_oe, 8'h00);
			ctl.idle(2);
		end
	endtask

	task automatic t_init();
		chk(done, 1'b0);
		ctl.init(INIT_P + 4);
		chk(done, 1'b1);
	endtask

	// Length eight write burst with upper bytes masked, then close the row.
	task automatic t_write_burst();
		ctl.issue(CMD_WR, 2'h1, 12'h020, 8'hf0,
			64'hfedc_ba98_7654_3210);
		chk(arr_wr, 8'h0f);
		chk(arr_wdata, 64'hfedc_ba98_7654_3210);
		ctl.idle(1);
		chk(arr_col, 8'h21);
		chk(arr_wdata, 64'h0123_4567_89ab_cdef);
		chk(arr_wr, 8'h0f);
		ctl.issue(CMD_BST, 2'h1, 12'h000, 8'h00, 64'h0);
		chk(arr_wr, 8'h00);
		ctl.issue(CMD_PRE, 2'h1, 12'h000, 8'h00, 64'h0);
		ctl.idle(2);
		ctl.issue(CMD_ACT, 2'h1, 12'h044, 8'h00, 64'h0);
		ctl.idle(1);
		chk(err, 1'b0);
	endtask

	// Activate to a bank that is already open must raise the fault flag.
	task automatic t_fault();
		ctl.issue(CMD_ACT, 2'h1, 12'h044, 8'h00, 64'h0);
		chk(err, 1'b0);
		ctl.idle(1);
		chk(err, 1'b1);
		ctl.idle(2);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#(40 * 3000);
		n_mismatch++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		t_init();
		t_write();
		t_read_mask();
		t_back_to_back();
		t_clock_gate();
		t_stop();
		t_write_burst();
		t_fault();
		stop_test();
	end
endmodule // sdmc_device_tb
